// File: logic/ivc_vector_ctrl.sv
// Interrupt selection and vector fetch: picks a trap or peripheral request,
// reads the four-byte vector entry over a byte port and hands back the routine start.
// Assumes the core holds its instruction stream while busy is high and the
// memory port answers every read with rdValid some cycles later.
// levelSelect is not read: levels arrive through the control register writes.
// Fixed traps other than break leave acceptedNumber as it was; read it for numbered vectors only.
// A source rewritten while it can request may lose that request.
// Operation
// (R1) Accepted request fetches its vector entry, then core continues at that address.
// (R2) Fixed vectors sit from FFFDC to FFFFF, four bytes each.
// (R3) Undefined-opcode trap uses FFFDC; overflow trap uses FFFE0.
// (R4) Break uses FFFE4 unless all FF, then variable-table break entry.
// (R5) Address-match uses FFFE8, gated by its own enable bit.
// (R6) Single-step and debugger-break vectors are for debug tools only.
// (R7) Variable entry address is table base plus byte offset 0 to 255.
// (R8) Number 0 serves break and ignores the global mask flag.
// (R9) Display events at 4 and 8, data slicer 19, vertical sync 20.
// (R10) Serial sources at numbers 9, 10, 13, 15, 16, 17, 18.
// (R11) Transfer channels at 11 and 12; conversion done at 14.
// (R12) A-group timers at 21 to 25; B-group timers at 26 to 28.
// (R13) External request pins at numbers 29 and 30.
// (R14) Numbers 5, 6, 7 and 31 have no request connected.
// (R15) Numbers 32 to 63 only by instruction, never masked.
// (R16) Each source has a request bit and a priority field.
// (R17) Global enable and threshold live in the processor flag word.
// (R18) Software rewrites a control register only when its source is quiet.
// (R19) Accept when enable set, request set and priority above threshold.
// (R20) Levels 0 to 7, 7 highest; level 0 never accepted.
// (R21) Hardware sets request, clears on accept; software may only clear.
// (R22) Entry holds 20-bit address, low byte first, upper bits ignored.
// (R23) Ties at one level go to the lowest source number.
`timescale 1ns/100ps
`default_nettype none
`include "ivc_consts.svh"
module ivc_vector_ctrl
  import ivc_pkg::*;
#(
  parameter int NSRC = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [NSRC-1:0] periphEvent,
  input wire logic [NSRC-1:0] icrWrite,
  input wire logic [3:0] icrWrData,
  input wire logic [NSRC*3-1:0] levelSelect,
  input wire logic [19:0] vectorTableBase,
  input wire logic globalEnable,
  input wire logic [2:0] processorPriorityThreshold,
  input wire logic addressMatchEnable,
  input wire logic addressMatchHit,
  input wire logic undefinedOpcodeTrap,
  input wire logic overflowTrap,
  input wire logic breakInstruction,
  input wire logic softIntStrobe,
  input wire logic [5:0] softIntNumber,
  input wire logic instrBoundary,
  output logic [NSRC-1:0] requestPending,
  output logic [NSRC*4-1:0] icrReadback,
  output logic rdReq,
  output logic [19:0] rdAddr,
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  output logic busy,
  output logic vectorValid,
  output logic [19:0] vectorAddr,
  output logic [5:0] acceptedNumber,
  output logic [2:0] acceptedLevel,
  output logic acceptedMaskable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ivc_state_t st;
    ivc_kind_t kind;
    logic [NSRC-1:0] req;
    logic [NSRC*3-1:0] lvl;
    logic [19:0] addr;
    logic [23:0] shift;
    logic [5:0] num;
    logic [2:0] level;
    logic maskable;
    logic valid;
  } ivc_regs_t;

  ivc_regs_t s_q;
  ivc_regs_t s_d;

  localparam logic [NSRC-1:0] CONNECTED =
    NSRC'(~`IVC_RESERVED_MASK & ~`IVC_UNUSED_MASK) | NSRC'(32'h0000_0010); // [R14]

  function automatic logic [19:0] varEntry(input logic [19:0] base, input logic [5:0] n);
    varEntry = base + {12'h000, n, 2'b00}; // [R7]
  endfunction : varEntry

  function automatic logic [2:0] lvlOf(input logic [NSRC*3-1:0] l, input int i);
    lvlOf = l[i*3 +: 3];
  endfunction : lvlOf

  function automatic logic [23:0] shiftIn(input logic [23:0] prev, input logic [7:0] b);
    shiftIn = {b, prev[23:8]};
  endfunction : shiftIn

  function automatic logic isFetch(input ivc_state_t st);
    isFetch = (st == IVC_RD0) || (st == IVC_RD1) || (st == IVC_RD2) || (st == IVC_CHKBRK);
  endfunction : isFetch

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  logic winHit;
  logic [4:0] winIdx;
  logic [2:0] winLvl;

  always_comb begin
    winHit = 1'b0;
    winIdx = 5'h00;
    winLvl = `IVC_LVL_OFF;
    // Strict greater keeps the lowest index on a tie [R23]
    for (int i = 0; i < NSRC; i++) begin
      if (s_q.req[i] && CONNECTED[i] && lvlOf(s_q.lvl, i) != `IVC_LVL_OFF // [R20]
          && lvlOf(s_q.lvl, i) > processorPriorityThreshold // [R19]
          && (!winHit || lvlOf(s_q.lvl, i) > winLvl)) begin
        winHit = 1'b1;
        winIdx = 5'(i);
        winLvl = lvlOf(s_q.lvl, i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [NSRC-1:0] reqNext;
  logic [NSRC*3-1:0] lvlNext;

  always_comb begin
    reqNext = s_q.req;
    lvlNext = s_q.lvl;
    // Hardware set beats software clear in the same cycle [R21]
    for (int i = 0; i < NSRC; i++) begin
      if (icrWrite[i]) begin
        if (!icrWrData[3]) begin
          reqNext[i] = 1'b0; // Software cannot set the bit [R21]
        end
        lvlNext[i*3 +: 3] = icrWrData[2:0]; // [R16]
      end
      if (periphEvent[i] && CONNECTED[i]) begin // [R9] [R10] [R11] [R12] [R13]
        reqNext[i] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request selection
  // ----------------------------------------------------------------
  logic takeGo;
  ivc_kind_t takeKind;
  logic [19:0] takeAddr;
  logic [5:0] takeNum;
  logic [2:0] takeLevel;
  logic takeMaskable;

  always_comb begin
    takeGo = 1'b0;
    takeKind = IVC_K_NONE;
    takeAddr = 20'h0_0000;
    takeNum = s_q.num;
    takeLevel = s_q.level;
    takeMaskable = 1'b0;
    // Undefined and overflow traps first, then break, address match, the soft instruction form, then peripherals
    if (undefinedOpcodeTrap) begin
      takeGo = 1'b1;
      takeKind = IVC_K_UNDEF;
      takeAddr = `IVC_FIX_UNDEF; // [R3]
    end else if (overflowTrap) begin
      takeGo = 1'b1;
      takeKind = IVC_K_OVFL;
      takeAddr = `IVC_FIX_OVFL; // [R3]
    end else if (breakInstruction) begin
      takeGo = 1'b1;
      takeKind = IVC_K_BREAK;
      takeAddr = `IVC_FIX_BREAK; // [R4] [R8]
      takeNum = 6'h00;
    end else if (addressMatchHit && addressMatchEnable) begin
      takeGo = 1'b1;
      takeKind = IVC_K_AMATCH;
      takeAddr = `IVC_FIX_AMATCH; // [R5]
    end else if (softIntStrobe) begin
      // Instruction form ignores the mask flag for every number [R15] [R8]
      takeGo = 1'b1;
      takeKind = IVC_K_SWINT;
      takeNum = softIntNumber;
      takeAddr = varEntry(vectorTableBase, softIntNumber);
    end else if (globalEnable && winHit) begin // [R17] [R19]
      takeGo = 1'b1;
      takeKind = IVC_K_PERIPH;
      takeNum = {1'b0, winIdx};
      takeLevel = winLvl;
      takeAddr = varEntry(vectorTableBase, {1'b0, winIdx});
      takeMaskable = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.req = reqNext;
    s_d.lvl = lvlNext;
    case (s_q.st)
      IVC_IDLE: begin
        // Trap and instruction triggers seen while busy are dropped, the core holds them; peripheral events stay in req
        if (instrBoundary && takeGo) begin
          s_d.kind = takeKind;
          s_d.addr = takeAddr;
          s_d.num = takeNum;
          s_d.level = takeLevel;
          s_d.maskable = takeMaskable;
          if (takeMaskable) begin
            // Clear at accept wins over a new event for the same source [R21]
            s_d.req[winIdx] = 1'b0;
          end
          s_d.st = IVC_RD0;
        end
      end
      IVC_RD0: begin
        if (rdValid) begin
          s_d.shift = shiftIn(s_q.shift, rdData); // Low byte first [R22]
          s_d.addr = s_q.addr + 20'h0_0001;
          s_d.st = IVC_RD1;
        end
      end
      IVC_RD1: begin
        if (rdValid) begin
          s_d.shift = shiftIn(s_q.shift, rdData); // [R22]
          s_d.addr = s_q.addr + 20'h0_0001;
          s_d.st = IVC_RD2;
        end
      end
      IVC_RD2: begin
        if (rdValid) begin
          s_d.shift = shiftIn(s_q.shift, rdData); // [R22]
          s_d.addr = s_q.addr + 20'h0_0001;
          s_d.st = IVC_CHKBRK;
        end
      end
      IVC_CHKBRK: begin
        // Fourth byte is read only for the all-ones check; upper bits ignored [R22]
        if (rdValid) begin
          if (s_q.kind == IVC_K_BREAK && rdData == `IVC_ALL_ONES
              && s_q.shift == {3{`IVC_ALL_ONES}}) begin
            s_d.kind = IVC_K_SWINT;
            s_d.addr = varEntry(vectorTableBase, 6'h00); // [R4] [R8]
            s_d.st = IVC_RD0;
          end else begin
            s_d.st = IVC_DONE;
          end
        end
      end
      IVC_DONE: begin
        s_d.valid = 1'b1; // [R1]
        s_d.st = IVC_IDLE;
      end
      default: begin
        s_d.st = IVC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      icrReadback[i*4 +: 4] = {s_q.req[i], s_q.lvl[i*3 +: 3]};
    end
  end

  assign requestPending = s_q.req;
  // The fourth byte is fetched even for plain vectors; one extra read per entry fetched
  assign rdReq = isFetch(s_q.st);
  assign rdAddr = s_q.addr;
  assign busy = (s_q.st != IVC_IDLE);
  assign vectorValid = s_q.valid;
  assign vectorAddr = s_q.shift[19:0]; // [R1] [R2]
  assign acceptedNumber = s_q.num;
  assign acceptedLevel = s_q.level;
  assign acceptedMaskable = s_q.maskable;

endmodule : ivc_vector_ctrl
`default_nettype wire

// File: pkg/ivc_consts.svh
// Constants for the interrupt vector and control block.
// Assumes inclusion by the design file only.
`ifndef IVC_CONSTS_SVH
`define IVC_CONSTS_SVH
`define IVC_FIX_UNDEF 20'hF_FFDC
`define IVC_FIX_OVFL 20'hF_FFE0
`define IVC_FIX_BREAK 20'hF_FFE4
`define IVC_FIX_AMATCH 20'hF_FFE8
`define IVC_FIX_SSTEP 20'hF_FFEC
`define IVC_FIX_DBGBRK 20'hF_FFF4
`define IVC_ENTRY_BYTES 3'h4
`define IVC_ALL_ONES 8'hFF
`define IVC_SRC_BITS 5'h1F
`define IVC_RESERVED_MASK 32'h8000_00E0
`define IVC_UNUSED_MASK 32'h0000_000F
`define IVC_LVL_OFF 3'h0
`define IVC_ICR_RESET 4'h0
`define IVC_TBASE_RESET 20'h0_0000
`endif

// File: pkg/ivc_pkg.sv
// Types for the interrupt vector and control block.
// Assumes a single clock domain.
package ivc_pkg;
  typedef enum logic [2:0] {
    IVC_IDLE, IVC_RD0, IVC_RD1, IVC_RD2, IVC_CHKBRK, IVC_DONE
  } ivc_state_t;
  typedef enum logic [2:0] {
    IVC_K_NONE, IVC_K_UNDEF, IVC_K_OVFL, IVC_K_BREAK, IVC_K_AMATCH, IVC_K_SWINT, IVC_K_PERIPH
  } ivc_kind_t;
endpackage : ivc_pkg

// File: bench/ivc_vector_ctrl_properties.sv
// Checker for the vector control block: fetch handshake, pulses, request bits.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/100ps
`default_nettype none
module ivc_vector_ctrl_properties #(
  parameter int NSRC = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic busy,
  input wire logic rdReq,
  input wire logic [19:0] rdAddr,
  input wire logic rdValid,
  input wire logic vectorValid,
  input wire logic [5:0] acceptedNumber,
  input wire logic [2:0] acceptedLevel,
  input wire logic acceptedMaskable,
  input wire logic [NSRC-1:0] requestPending,
  input wire logic [2:0] processorPriorityThreshold
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_valid_pulse: assert property (vectorValid |=> !vectorValid)
    else $error("vectorValid too long");
  a_answer_bound: assert property ($rose(busy) |-> ##[1:200] vectorValid)
    else $error("no vector");
  a_fetch_busy: assert property (rdReq |-> busy)
    else $error("read while idle");
  a_read_hold: assert property (rdReq && !rdValid |=> rdReq && $stable(rdAddr))
    else $error("read dropped");
  a_byte_step: assert property (rdReq && rdValid && rdAddr[1:0] != 2'h3
    |=> rdReq && rdAddr == $past(rdAddr) + 20'h1) else $error("byte order");
  a_level_gate: assert property (vectorValid && acceptedMaskable
    |-> acceptedLevel > processorPriorityThreshold) else $error("level not above");
  a_level_zero: assert property (vectorValid && acceptedMaskable |-> acceptedLevel != 3'h0)
    else $error("level 0 taken");
  a_req_cleared: assert property (vectorValid && acceptedMaskable
    |-> !requestPending[acceptedNumber[4:0]]) else $error("request kept");
  a_swint_unmasked: assert property (vectorValid && acceptedNumber[5] |-> !acceptedMaskable)
    else $error("high number masked");
  a_reserved_quiet: assert property ((requestPending & 32'h8000_00EF) == 32'h0)
    else $error("reserved pending");
  a_debug_unused: assert property (rdReq |-> rdAddr[19:2] != 18'h3_FFFB
    && rdAddr[19:2] != 18'h3_FFFD) else $error("debug vector read");
  c_maskable: cover property (vectorValid && acceptedMaskable);
  c_break_var: cover property (vectorValid && acceptedNumber == 6'h0);
  c_slow_read: cover property (rdReq && !rdValid);
endmodule : ivc_vector_ctrl_properties
bind ivc_vector_ctrl ivc_vector_ctrl_properties #(.NSRC(NSRC)) u_props (.clock, .rstn, .busy,
  .rdReq, .rdAddr, .rdValid, .vectorValid, .acceptedNumber, .acceptedLevel, .acceptedMaskable,
  .requestPending, .processorPriorityThreshold);
`default_nettype wire

// File: bench/ivc_mem_model.sv
// Byte memory behind the vector fetch port; fast or slow answers.
// Assumes the reader holds rdReq and rdAddr until rdValid.
`timescale 1ns/100ps
`default_nettype none
module ivc_mem_model (
  input wire logic clock,
  input wire logic rdReq,
  input wire logic [19:0] rdAddr,
  input wire logic slow,
  input wire logic brkFf,
  output logic rdValid,
  output logic [7:0] rdData
);
  logic [1:0] waitQ = 2'h0;
  logic [7:0] byteVal;
  // Break entry can be blanked to all ones to force the fallback
  assign byteVal = (brkFf && rdAddr[19:2] == 18'h3_FFF9) ? 8'hFF : rdAddr[7:0] ^ 8'h5A;
  assign rdValid = rdReq && (!slow || waitQ == 2'h3);
  // Outside a valid answer the bus shows garbage, not the last byte
  assign rdData = rdValid ? byteVal : ~byteVal;
  always_ff @(posedge clock) waitQ <= (rdReq && !rdValid) ? waitQ + 2'h1 : 2'h0;
endmodule : ivc_mem_model
`default_nettype wire

// File: bench/ivc_vector_ctrl_test.sv
// Self-checking bench for the vector control block.
// Assumes the memory model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module ivc_vector_ctrl_test;
  logic clock = 0, rstn = 0, globalEnable = 1, addressMatchEnable = 0, instrBoundary = 0;
  logic addressMatchHit = 0, undefinedOpcodeTrap = 0, overflowTrap = 0, breakInstruction = 0;
  logic softIntStrobe = 0, rdReq, rdValid, busy, vectorValid, acceptedMaskable, slow = 0;
  logic brkFf = 0;
  logic [31:0] periphEvent = 0, icrWrite = 0, requestPending;
  logic [127:0] icrReadback;
  logic [3:0] icrWrData = 0;
  logic [19:0] vectorTableBase = 20'h1_2340, rdAddr, vectorAddr;
  logic [2:0] processorPriorityThreshold = 0, acceptedLevel;
  logic [5:0] softIntNumber = 0, acceptedNumber;
  logic [7:0] rdData;
  int mismatches = 0, checkCount = 0, n;
  ivc_vector_ctrl u_ivc_vector_ctrl (.clock, .rstn, .periphEvent, .icrWrite, .icrWrData,
    .levelSelect(96'h0), .vectorTableBase, .globalEnable, .processorPriorityThreshold,
    .addressMatchEnable, .addressMatchHit, .undefinedOpcodeTrap, .overflowTrap,
    .breakInstruction, .softIntStrobe, .softIntNumber, .instrBoundary, .requestPending,
    .icrReadback, .rdReq, .rdAddr, .rdValid, .rdData, .busy, .vectorValid, .vectorAddr,
    .acceptedNumber, .acceptedLevel, .acceptedMaskable);
  ivc_mem_model u_ivc_mem_model (.clock, .rdReq, .rdAddr, .slow, .brkFf, .rdValid, .rdData);
  initial forever #2 clock = ~clock;
  // ----------
  // Tasks
  // ----------
  function automatic logic [19:0] ev(input logic [19:0] a);
    logic [7:0] x;
    x = (a + 20'h2) ^ 8'h5A;
    return {x[3:0], 8'((a + 20'h1) ^ 8'h5A), 8'(a ^ 8'h5A)};
  endfunction : ev
  task automatic end_sim;
    if (mismatches == 0 && checkCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic fire(input logic [4:0] t);
    @(posedge clock);
    {undefinedOpcodeTrap, overflowTrap, breakInstruction, softIntStrobe, addressMatchHit,
      instrBoundary} <= {t, 1'b1};
    @(posedge clock);
    {undefinedOpcodeTrap, overflowTrap, breakInstruction, softIntStrobe, addressMatchHit,
      instrBoundary} <= 6'h0;
  endtask : fire
  // Number 6'h3F skips the number compare for fixed traps
  task automatic run(input logic [4:0] t, input logic [19:0] ea, input logic [5:0] en);
    int i;
    fire(t);
    for (i = 0; i < 100; i++) begin
      @(negedge clock);
      if (vectorValid === 1'b1) break;
    end
    if (i == 100) begin mismatches++; end_sim(); end
    `CHK(vectorAddr, ea)
    if (en != 6'h3F) `CHK(acceptedNumber, en)
  endtask : run
  task automatic quiet(input logic [4:0] t);
    fire(t);
    repeat (4) @(negedge clock);
    `CHK(busy, 1'b0)
  endtask : quiet
  // Called while the source is quiet, except the last clear of source 4, made with its request pending
  task automatic wr(input int s, input logic [3:0] d);
    @(posedge clock) {icrWrite, icrWrData} <= {32'h1 << s, d};
    @(posedge clock) icrWrite <= 32'h0;
    @(negedge clock);
  endtask : wr
  task automatic pulse(input logic [31:0] m);
    @(posedge clock) periphEvent <= m;
    @(posedge clock) periphEvent <= 32'h0;
    @(negedge clock);
  endtask : pulse
  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1;
    run(5'h10, ev(20'hF_FFDC), 6'h3F);
    run(5'h08, ev(20'hF_FFE0), 6'h3F);
    run(5'h04, ev(20'hF_FFE4), 6'h3F);
    {brkFf, globalEnable, slow} <= 3'b101;
    run(5'h04, ev(vectorTableBase), 6'h0);
    quiet(5'h01);
    {brkFf, addressMatchEnable} <= 2'b01;
    run(5'h01, ev(20'hF_FFE8), 6'h3F);
    for (n = 32; n < 64; n += 31) begin
      softIntNumber <= 6'(n);
      run(5'h02, ev(vectorTableBase + 20'(4 * n)), 6'(n));
    end
    {globalEnable, slow} <= 2'b10;
    for (n = 4; n < 31; n++) if (n < 5 || n > 7) begin
      wr(n, 4'h9);
      `CHK(icrReadback[n*4+:4], 4'h1)
      pulse(32'h1 << n);
      run(5'h0, ev(vectorTableBase + 20'(4 * n)), 6'(n));
      `CHK(requestPending[n], 1'b0)
    end
    pulse(32'h8000_00EF);
    `CHK(requestPending, 32'h0)
    wr(9, 4'hB);
    wr(13, 4'hB);
    wr(4, 4'h8);
    {globalEnable, processorPriorityThreshold} <= 4'h2;
    pulse(32'h0000_2210);
    quiet(5'h0);
    {globalEnable, processorPriorityThreshold} <= 4'hB;
    quiet(5'h0);
    processorPriorityThreshold <= 3'h2;
    run(5'h0, ev(vectorTableBase + 20'd36), 6'd9);
    run(5'h0, ev(vectorTableBase + 20'd52), 6'd13);
    `CHK(requestPending[4], 1'b1)
    wr(4, 4'h0);
    wr(4, 4'h8);
    @(negedge clock);
    `CHK(requestPending[4], 1'b0)
    end_sim();
  end
endmodule : ivc_vector_ctrl_test
`default_nettype wire
